// file: inc/irq_slice_pkg.sv
`default_nettype none
package irq_slice_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;

    // register byte offsets
    localparam logic [7:0] OFS_FLAGS_THIRD   = 8'h00;
    localparam logic [7:0] OFS_FLAGS_FOURTH  = 8'h04;
    localparam logic [7:0] OFS_FLAGS_FIFTH   = 8'h08;
    localparam logic [7:0] OFS_ENABLES_FIRST = 8'h0c;
    localparam logic [7:0] OFS_EVENT_STATUS  = 8'h10;
    localparam logic [7:0] OFS_EVENT_MASK    = 8'h14;

    // third flag register fields
    localparam int unsigned CALENDAR_CLOCK_FLAG   = 14;
    localparam int unsigned EXT_IRQ_FOUR_FLAG     = 6;
    localparam int unsigned EXT_IRQ_THREE_FLAG    = 5;
    localparam int unsigned I2C_TWO_MASTER_FLAG   = 2;
    localparam int unsigned I2C_TWO_SLAVE_FLAG    = 1;
    // fourth flag register fields
    localparam int unsigned TOUCH_MEASURE_FLAG    = 13;
    localparam int unsigned LOW_VOLTAGE_FLAG      = 8;
    localparam int unsigned CHECKSUM_GEN_FLAG     = 3;
    localparam int unsigned UART_TWO_ERROR_FLAG   = 2;
    localparam int unsigned UART_ONE_ERROR_FLAG   = 1;
    // fifth flag register fields
    localparam int unsigned CAPTURE_NINE_FLAG     = 13;
    localparam int unsigned COMPARE_NINE_FLAG     = 12;
    localparam int unsigned SERIAL_THREE_EVENT_FLAG = 11;
    localparam int unsigned SERIAL_THREE_FAULT_FLAG = 10;
    localparam int unsigned UART_FOUR_TX_FLAG     = 9;
    localparam int unsigned UART_FOUR_RX_FLAG     = 8;
    localparam int unsigned UART_FOUR_ERROR_FLAG  = 7;
    localparam int unsigned OTG_PORT_FLAG         = 6;
    localparam int unsigned I2C_THREE_MASTER_FLAG = 5;
    localparam int unsigned I2C_THREE_SLAVE_FLAG  = 4;
    localparam int unsigned UART_THREE_TX_FLAG    = 3;
    localparam int unsigned UART_THREE_RX_FLAG    = 2;
    localparam int unsigned UART_THREE_ERROR_FLAG = 1;
    // first enable register fields
    localparam int unsigned ADC_DONE_ENABLE         = 13;
    localparam int unsigned UART_ONE_TX_ENABLE      = 12;
    localparam int unsigned UART_ONE_RX_ENABLE      = 11;
    localparam int unsigned SERIAL_ONE_XFER_ENABLE  = 10;
    localparam int unsigned SERIAL_ONE_FAULT_ENABLE = 9;
    localparam int unsigned TIMER_THREE_ENABLE      = 8;
    localparam int unsigned TIMER_TWO_ENABLE        = 7;
    localparam int unsigned COMPARE_TWO_ENABLE      = 6;
    localparam int unsigned CAPTURE_TWO_ENABLE      = 5;
    localparam int unsigned TIMER_ONE_ENABLE        = 3;
    localparam int unsigned COMPARE_ONE_ENABLE      = 2;
    localparam int unsigned CAPTURE_ONE_ENABLE      = 1;
    localparam int unsigned EXT_IRQ_ZERO_ENABLE     = 0;

    // implemented-bit masks: everything else is hardwired zero
    localparam logic [15:0] IMPL_FLAGS_THIRD   = 16'h4066;
    localparam logic [15:0] IMPL_FLAGS_FOURTH  = 16'h210e;
    localparam logic [15:0] IMPL_FLAGS_FIFTH   = 16'h3ffe;
    localparam logic [15:0] IMPL_ENABLES_FIRST = 16'h3fef;

    localparam logic [15:0] RST_FLAGS   = 16'h0000;
    localparam logic [15:0] RST_ENABLES = 16'h0000;

    // event status / mask layout
    localparam int unsigned EVT_W         = 3;
    localparam int unsigned EVT_THIRD     = 0;
    localparam int unsigned EVT_FOURTH    = 1;
    localparam int unsigned EVT_FIFTH     = 2;
    localparam logic [2:0]  RST_EVT       = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one register write, carried from the bus front end to the banks
    typedef struct packed {
        logic              en;
        logic [7:0]        addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } reg_wr_s;

    // bit mask of the byte lanes that reach a 16-bit register
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage
`default_nettype wire

// file: logic/flag_bank.sv
`timescale 1ns/100ps
`default_nettype none
module flag_bank #(
    parameter logic [15:0] IMPL = 16'h0000
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // source pulses
    input  wire logic [15:0] src,
    // software write
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] wmask,
    // state
    output logic      [15:0] flags,
    output logic             event_hit
);

    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [15:0] written;

    // a source pulse in the cycle of a clearing write still lands
    assign written   = wr ? ((wdata & wmask) | (flags_r & ~wmask)) : flags_r;
    assign flags_nxt = (written | src) & IMPL;
    assign flags     = flags_r;
    assign event_hit = |(src & IMPL);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= irq_slice_pkg::RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule
`default_nettype wire

// file: logic/axil_front.sv
`timescale 1ns/100ps
`default_nettype none
module axil_front (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // write address and data
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // write response
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // register side
    output irq_slice_pkg::reg_wr_s     reg_wr,
    input  wire logic                  wr_hit,
    output logic                       rd_take,
    output logic [7:0]                 rd_addr,
    input  wire logic [31:0]           rd_data,
    input  wire logic                  rd_hit
);

    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_hs, w_hs, wr_fire;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic        awready_r, wready_r, arready_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;

    assign aw_hs      = awvalid && awready_r;
    assign w_hs       = wvalid && wready_r;
    assign wr_fire    = (aw_got_r || aw_hs) && (w_got_r || w_hs);
    assign aw_got_nxt = (aw_got_r || aw_hs) && !wr_fire;
    assign w_got_nxt  = (w_got_r || w_hs) && !wr_fire;
    assign bvalid_nxt = wr_fire || (bvalid_r && !bready);
    assign rd_take    = arvalid && arready_r;
    assign rvalid_nxt = rd_take || (rvalid_r && !rready);
    assign rd_addr    = araddr;

    assign reg_wr.en   = wr_fire;
    assign reg_wr.addr = aw_got_r ? aw_addr_r : awaddr;
    assign reg_wr.data = w_got_r ? w_data_r : wdata;
    assign reg_wr.strb = w_got_r ? w_strb_r : wstrb;

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= irq_slice_pkg::RESP_OKAY;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            if (aw_hs) begin
                aw_addr_r <= awaddr;
            end
            if (w_hs) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            bvalid_r  <= bvalid_nxt;
            if (wr_fire) begin
                bresp_r <= wr_hit ? irq_slice_pkg::RESP_OKAY : irq_slice_pkg::RESP_SLVERR;
            end
            // one write at a time: channels close until the response is taken
            awready_r <= !aw_got_nxt && !bvalid_nxt;
            wready_r  <= !w_got_nxt && !bvalid_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= irq_slice_pkg::RESP_OKAY;
            arready_r <= 1'b0;
        end else begin
            rvalid_r  <= rvalid_nxt;
            arready_r <= !rvalid_nxt;
            if (rd_take) begin
                rdata_r <= rd_data;
                rresp_r <= rd_hit ? irq_slice_pkg::RESP_OKAY : irq_slice_pkg::RESP_SLVERR;
            end
        end
    end

endmodule
`default_nettype wire

// file: logic/irq_flag_enable_bank_slice.sv
// Summary of operation
// - third flags: calendar, ext four/three, i2c two
// - fourth flags: touch, low voltage, checksum, uart errors
// - fifth flags: capture/compare nine through uart three
// - first enables: adc done down to ext zero
// - flag reads one once its source requested
// - enable one passes request, zero blocks it
// - implemented bits read/write, zero after reset
// - unassigned bits ignore writes, read zero
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_enable_bank_slice (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // axi4-lite write
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // peripheral request pulses, one bit per flag position
    input  wire logic [15:0] SRC_FLAGS_THIRD,
    input  wire logic [15:0] SRC_FLAGS_FOURTH,
    input  wire logic [15:0] SRC_FLAGS_FIFTH,
    // flags of the first group, held elsewhere in the controller
    input  wire logic [15:0] FLAGS_FIRST,
    // towards the core
    output logic [15:0]      CORE_REQ_FIRST,
    output logic             IRQ
);

    irq_slice_pkg::reg_wr_s reg_wr;
    logic        wr_hit, rd_take, rd_hit;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic [15:0] wmask;
    logic        wr_f3, wr_f4, wr_f5, wr_en0, wr_mask;
    logic        rd_f3, rd_f4, rd_f5, rd_en0, rd_stat, rd_mask;
    logic [15:0] flags3, flags4, flags5;
    logic        hit3, hit4, hit5;
    logic [15:0] en_r, en_nxt;
    logic [15:0] req_r, req_nxt;
    logic [2:0]  stat_r, stat_nxt, mask_r, mask_nxt, evt;
    logic        irq_r, irq_nxt;

    axil_front u_front (
        .clk     (CLK),
        .resetn  (RESETN),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .reg_wr  (reg_wr),
        .wr_hit  (wr_hit),
        .rd_take (rd_take),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // write decode
    assign wmask   = irq_slice_pkg::lane_mask(reg_wr.strb);
    assign wr_f3   = reg_wr.en && (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_THIRD);
    assign wr_f4   = reg_wr.en && (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_FOURTH);
    assign wr_f5   = reg_wr.en && (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_FIFTH);
    assign wr_en0  = reg_wr.en && (reg_wr.addr == irq_slice_pkg::OFS_ENABLES_FIRST);
    assign wr_mask = reg_wr.en && (reg_wr.addr == irq_slice_pkg::OFS_EVENT_MASK);
    // the status word is read-only but a write to it is answered OKAY and dropped
    assign wr_hit  = (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_THIRD)
                   || (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_FOURTH)
                   || (reg_wr.addr == irq_slice_pkg::OFS_FLAGS_FIFTH)
                   || (reg_wr.addr == irq_slice_pkg::OFS_ENABLES_FIRST)
                   || (reg_wr.addr == irq_slice_pkg::OFS_EVENT_STATUS)
                   || (reg_wr.addr == irq_slice_pkg::OFS_EVENT_MASK);

    // read decode
    assign rd_f3   = (rd_addr == irq_slice_pkg::OFS_FLAGS_THIRD);
    assign rd_f4   = (rd_addr == irq_slice_pkg::OFS_FLAGS_FOURTH);
    assign rd_f5   = (rd_addr == irq_slice_pkg::OFS_FLAGS_FIFTH);
    assign rd_en0  = (rd_addr == irq_slice_pkg::OFS_ENABLES_FIRST);
    assign rd_stat = (rd_addr == irq_slice_pkg::OFS_EVENT_STATUS);
    assign rd_mask = (rd_addr == irq_slice_pkg::OFS_EVENT_MASK);
    assign rd_hit  = rd_f3 || rd_f4 || rd_f5 || rd_en0 || rd_stat || rd_mask;
    // upper half and unassigned bits read zero
    assign rd_data = rd_f3   ? {16'h0000, flags3}
                   : rd_f4   ? {16'h0000, flags4}
                   : rd_f5   ? {16'h0000, flags5}
                   : rd_en0  ? {16'h0000, en_r}
                   : rd_stat ? {29'h0000_0000, stat_r}
                   : rd_mask ? {29'h0000_0000, mask_r}
                   : 32'h0000_0000;

    flag_bank #(.IMPL(irq_slice_pkg::IMPL_FLAGS_THIRD)) u_third (
        .clk       (CLK),
        .resetn    (RESETN),
        .src       (SRC_FLAGS_THIRD),
        .wr        (wr_f3),
        .wdata     (reg_wr.data[15:0]),
        .wmask     (wmask),
        .flags     (flags3),
        .event_hit (hit3)
    );

    flag_bank #(.IMPL(irq_slice_pkg::IMPL_FLAGS_FOURTH)) u_fourth (
        .clk       (CLK),
        .resetn    (RESETN),
        .src       (SRC_FLAGS_FOURTH),
        .wr        (wr_f4),
        .wdata     (reg_wr.data[15:0]),
        .wmask     (wmask),
        .flags     (flags4),
        .event_hit (hit4)
    );

    flag_bank #(.IMPL(irq_slice_pkg::IMPL_FLAGS_FIFTH)) u_fifth (
        .clk       (CLK),
        .resetn    (RESETN),
        .src       (SRC_FLAGS_FIFTH),
        .wr        (wr_f5),
        .wdata     (reg_wr.data[15:0]),
        .wmask     (wmask),
        .flags     (flags5),
        .event_hit (hit5)
    );

    // enable register, only the documented positions hold state
    assign en_nxt  = (wr_en0 ? ((reg_wr.data[15:0] & wmask) | (en_r & ~wmask)) : en_r)
                   & irq_slice_pkg::IMPL_ENABLES_FIRST;
    // registered so the core sees a clean flop; costs one cycle of latency
    assign req_nxt = FLAGS_FIRST & en_nxt;

    // a source pulse on an implemented bit of a bank is an event; a status read clears,
    // but an event in that same cycle survives the clear
    assign evt      = {hit5, hit4, hit3};
    assign stat_nxt = ((rd_take && rd_stat) ? irq_slice_pkg::RST_EVT : stat_r) | evt;
    assign mask_nxt = wr_mask && reg_wr.strb[0] ? reg_wr.data[2:0] : mask_r;
    assign irq_nxt  = |(stat_nxt & mask_nxt);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_r   <= irq_slice_pkg::RST_ENABLES;
            req_r  <= 16'h0000;
            stat_r <= irq_slice_pkg::RST_EVT;
            mask_r <= irq_slice_pkg::RST_EVT;
            irq_r  <= 1'b0;
        end else begin
            en_r   <= en_nxt;
            req_r  <= req_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign CORE_REQ_FIRST = req_r;
    assign IRQ            = irq_r;

endmodule
`default_nettype wire

// file: sim/irq_slice_chk.sv
`timescale 1ns/100ps
`default_nettype none
module irq_slice_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESETN,
    // bus
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // core side
    input wire logic [15:0] FLAGS_FIRST,
    input wire logic [15:0] CORE_REQ_FIRST,
    input wire logic        IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    wire logic        ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire logic        wr_any  = (S_AXI_AWVALID && S_AXI_AWREADY) || (S_AXI_WVALID && S_AXI_WREADY);
    wire logic [7:0]  a       = S_AXI_ARADDR;
    // expected set of readable bits per address; zero mask marks an unmapped read
    wire logic [15:0] mask_nxt = (a == 8'h00) ? irq_slice_pkg::IMPL_FLAGS_THIRD :
                                 (a == 8'h04) ? irq_slice_pkg::IMPL_FLAGS_FOURTH :
                                 (a == 8'h08) ? irq_slice_pkg::IMPL_FLAGS_FIFTH :
                                 (a == 8'h0c) ? irq_slice_pkg::IMPL_ENABLES_FIRST :
                                 (a == 8'h10 || a == 8'h14) ? 16'h0007 : 16'h0000;
    logic [15:0] rd_mask_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_mask_r <= 16'h0000;
        end else if (ar_take) begin
            rd_mask_r <= mask_nxt;
        end
    end

    AST_B_AFTER_WRITE: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID) else $error("no write response after write");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    AST_AW_CLOSED: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("write address reopened early");
    AST_R_AFTER_READ: assert property (ar_take |=> S_AXI_RVALID) else $error("no read data after read address");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data changed while waiting");
    AST_UNUSED_ZERO: assert property (S_AXI_RVALID |-> (S_AXI_RDATA & ~{16'h0000, rd_mask_r}) == 32'h0) else $error("unassigned bit read as one");
    AST_RESP_CODE: assert property (S_AXI_RVALID |-> S_AXI_RRESP == ((rd_mask_r != 16'h0000) ? irq_slice_pkg::RESP_OKAY : irq_slice_pkg::RESP_SLVERR)) else $error("wrong read response");
    AST_CORE_GATED: assert property (1'b1 |=> (CORE_REQ_FIRST & ~($past(FLAGS_FIRST) & irq_slice_pkg::IMPL_ENABLES_FIRST)) == 16'h0) else $error("core request without flag");
    AST_IRQ_STICKY: assert property (IRQ && !ar_take && !wr_any |=> IRQ) else $error("interrupt dropped without software action");
endmodule
`default_nettype wire

// file: sim/periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module periph_model (
    // clock
    input  wire logic        clk,
    // request lines of the three flag groups
    output logic      [15:0] src_third,
    output logic      [15:0] src_fourth,
    output logic      [15:0] src_fifth,
    // first-group flag levels
    output logic      [15:0] flags_first
);
    initial begin
        src_third = 16'h0000;
        src_fourth = 16'h0000;
        src_fifth = 16'h0000;
        flags_first = 16'h0000;
    end

    // a single-cycle pulse: the flag must outlive its source by itself
    task automatic pulse(input int unsigned grp, input logic [15:0] bits);
        @(posedge clk);
        if (grp == 0) src_third <= bits;
        if (grp == 1) src_fourth <= bits;
        if (grp == 2) src_fifth <= bits;
        @(posedge clk);
        src_third <= 16'h0000;
        src_fourth <= 16'h0000;
        src_fifth <= 16'h0000;
    endtask

    task automatic level(input logic [15:0] v);
        @(posedge clk);
        flags_first <= v;
    endtask
endmodule
`default_nettype wire

// file: sim/tb_irq_flag_enable_bank_slice.sv
`timescale 1ns/100ps
`default_nettype none
module tb_irq_flag_enable_bank_slice;
    logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  r;
    wire logic        awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] s3, s4, s5, ff, req;
    int          fail_count, compares;
    logic [15:0] impl [4] = '{irq_slice_pkg::IMPL_FLAGS_THIRD, irq_slice_pkg::IMPL_FLAGS_FOURTH,
                              irq_slice_pkg::IMPL_FLAGS_FIFTH, irq_slice_pkg::IMPL_ENABLES_FIRST};
    int unsigned sbit [3] = '{irq_slice_pkg::CALENDAR_CLOCK_FLAG, irq_slice_pkg::LOW_VOLTAGE_FLAG,
                              irq_slice_pkg::OTG_PORT_FLAG};
    logic [31:0] sexp [3] = '{32'h0000_4000, 32'h0000_0100, 32'h0000_0040};

    irq_flag_enable_bank_slice dut (.CLK(clk), .RESETN(resetn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SRC_FLAGS_THIRD(s3), .SRC_FLAGS_FOURTH(s4), .SRC_FLAGS_FIFTH(s5),
        .FLAGS_FIRST(ff), .CORE_REQ_FIRST(req), .IRQ(irq));
    periph_model per (.clk(clk), .src_third(s3), .src_fourth(s4), .src_fifth(s5), .flags_first(ff));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sampling at the falling edge sees what the next rising edge will take
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        logic pa, pw, ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        ta = 1'b0;
        while (!ta) begin
            @(negedge clk);
            ta = bvalid;
            r = bresp;
            @(posedge clk);
        end
        bready <= 1'b0;
        chk_resp(r, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        logic t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end
        rready <= 1'b0;
        chk_word(d, ev);
        chk_resp(r, er);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    localparam logic [1:0] OK = irq_slice_pkg::RESP_OKAY;
    localparam logic [1:0] ER = irq_slice_pkg::RESP_SLVERR;

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, resetn} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        fail_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, OK);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(8'(i * 4), 32'hffff_ffff, 4'hf, OK);
            rd(8'(i * 4), {16'h0, impl[i]}, OK);
            // zeroes on lane 1 only: the low byte must keep its ones
            wr(8'(i * 4), 32'h0, 4'h2, OK);
            rd(8'(i * 4), {24'h0, impl[i][7:0]}, OK);
            wr(8'(i * 4), 32'h0, 4'hf, OK);
            rd(8'(i * 4), 32'h0, OK);
        end
        $display("test read write done");
        for (int g = 0; g < 3; g++) begin
            per.pulse(g, 16'h1 << sbit[g]);
            rd(8'(g * 4), sexp[g], OK);
            per.pulse(g, 16'hffff);
            rd(8'(g * 4), {16'h0, impl[g]}, OK);
            rd(8'(g * 4), {16'h0, impl[g]}, OK);
            wr(8'(g * 4), 32'h0, 4'hf, OK);
            rd(8'(g * 4), 32'h0, OK);
        end
        $display("test flag sources done");
        per.level(16'hffff);
        wr(8'h0c, 32'h0000_ffff, 4'hf, OK);
        settle();
        chk_word({16'h0, req}, {16'h0, impl[3]});
        wr(8'h0c, 32'h0, 4'hf, OK);
        settle();
        chk_word({16'h0, req}, 32'h0);
        wr(8'h0c, 32'h0000_2001, 4'hf, OK);
        settle();
        chk_word({16'h0, req}, 32'h0000_2001);
        per.level(16'h0000);
        settle();
        chk_word({16'h0, req}, 32'h0);
        $display("test enables done");
        rd(8'h10, 32'h7, OK);
        rd(8'h10, 32'h0, OK);
        wr(8'h14, 32'h2, 4'hf, OK);
        per.pulse(0, 16'h0002);
        settle();
        chk_word({31'h0, irq}, 32'h0);
        per.pulse(1, 16'h0002);
        settle();
        chk_word({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h0, 4'hf, OK);
        settle();
        chk_word({31'h0, irq}, 32'h1);
        rd(8'h10, 32'h3, OK);
        settle();
        chk_word({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        wr(8'h20, 32'hffff_ffff, 4'hf, ER);
        rd(8'h20, 32'h0, ER);
        rd(8'h18, 32'h0, ER);
        $display("test unmapped done");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule

bind irq_flag_enable_bank_slice irq_slice_chk chk (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .FLAGS_FIRST(FLAGS_FIRST), .CORE_REQ_FIRST(CORE_REQ_FIRST), .IRQ(IRQ));
`default_nettype wire
